/* File: hw/pwm_cfg.svh */
// Register offsets, field positions, reset values and timing constants of the PWM block
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define ADDR_W 8
`define OFS_CONTROL 8'h20
`define OFS_DUTY_LOW 8'h21
`define OFS_DUTY_HIGH 8'h22
`define OFS_PIN_FUNC 8'h14
`define RST_NIBBLE 4'h0
`define POL_BIT 3
`define SEL_HI 2
`define FINE_HI 1
`define LOWBASE_HI 3
`define LOWBASE_LO 2
`define PIN3_HI 3
`define PIN3_LO 2
`define PIN2_HI 1
`define PIN2_LO 0
`define PIN_PWM_SEL 2'h3
`define SUB_CLOCKS 7'h40
`define SUB_LAST 6'h3f
`define SUB_COUNT_LAST 2'h3
`define PRE_W 11
`define PRE_LAST_0 11'h000
`define PRE_LAST_1 11'h001
`define PRE_LAST_2 11'h003
`define PRE_LAST_3 11'h007
`define PRE_LAST_4 11'h01f
`define PRE_LAST_5 11'h07f
`define PRE_LAST_6 11'h1ff
`define PRE_LAST_7 11'h7ff
`define DIV_0 12'h001
`define DIV_1 12'h002
`define DIV_2 12'h004
`define DIV_3 12'h008
`define DIV_4 12'h020
`define DIV_5 12'h080
`define DIV_6 12'h200
`define DIV_7 12'h800
`endif

/* File: hw/pwm_pkg.sv */
// Types shared by the PWM block
package pwm_pkg;
  typedef logic [3:0] nibble_t;
  typedef logic [5:0] duty_base_t;
  typedef enum logic {run_st, stopped_st} run_state_t;
endpackage

/* File: hw/pwm_six_plus_two_bit.sv */
// (6+2)-bit pulse width modulator with its nibble register file
//
// How it works
// - Clock select picks 1..2048 oscillator periods
// - Polarity bit inverts the output waveform
// - Period is four sub-cycles of 64 clocks
// - Base duty six bits, fine tune two
// - First n sub-cycles use base plus one
// - High write reloads; effect at next period
// - Runs in halt, stops in stop
// - Pin output only when field is 11
// - Field 11 switches function and pin on
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "pwm_cfg.svh"

module pwm_six_plus_two_bit (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic [7:0] addr,
  input wire logic [3:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [3:0] rdata,
  output logic pwm_pin_out,
  output logic pwm_pin_oe,
  output logic alternate_waveform_pin,
  output logic alternate_waveform_pin_oe,
  output logic pwm_wave
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Terminal count of the prescaler for a clock-select code
  function automatic logic [`PRE_W-1:0] pre_last(input logic [2:0] sel);
    case (sel)
      3'h0: pre_last = `PRE_LAST_0;
      3'h1: pre_last = `PRE_LAST_1;
      3'h2: pre_last = `PRE_LAST_2;
      3'h3: pre_last = `PRE_LAST_3;
      3'h4: pre_last = `PRE_LAST_4;
      3'h5: pre_last = `PRE_LAST_5;
      3'h6: pre_last = `PRE_LAST_6;
      default: pre_last = `PRE_LAST_7;
    endcase
  endfunction

  // Oscillator periods per PWM clock, kept apart from the prescaler for checking
  function automatic logic [11:0] div_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: div_ratio = `DIV_0;
      3'h1: div_ratio = `DIV_1;
      3'h2: div_ratio = `DIV_2;
      3'h3: div_ratio = `DIV_3;
      3'h4: div_ratio = `DIV_4;
      3'h5: div_ratio = `DIV_5;
      3'h6: div_ratio = `DIV_6;
      default: div_ratio = `DIV_7;
    endcase
  endfunction

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------

  pwm_pkg::nibble_t waveform_control_reg_q;
  pwm_pkg::nibble_t duty_low_q;
  pwm_pkg::nibble_t duty_high_q;
  pwm_pkg::nibble_t pin_func_q;
  logic reload_req_q;
  logic reload_take;

  // Software writes; high nibble write raises a reload request
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      waveform_control_reg_q <= `RST_NIBBLE;
      duty_low_q <= `RST_NIBBLE;
      duty_high_q <= `RST_NIBBLE;
      pin_func_q <= `RST_NIBBLE;
    end
    else if (clk_en && wr_stb)
    begin
      if (hit(addr, `OFS_CONTROL))
        waveform_control_reg_q <= wdata;
      if (hit(addr, `OFS_DUTY_LOW))
        duty_low_q <= wdata;
      if (hit(addr, `OFS_DUTY_HIGH))
        duty_high_q <= wdata;
      if (hit(addr, `OFS_PIN_FUNC))
        pin_func_q <= wdata;
    end
  end

  // Pending reload: a new write wins over the consume in the same cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
      reload_req_q <= 1'b0;
    else if (clk_en)
    begin
      if (wr_stb && hit(addr, `OFS_DUTY_HIGH))
        reload_req_q <= 1'b1;
      else if (reload_take)
        reload_req_q <= 1'b0;
    end
  end

  // Read data one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdata <= `RST_NIBBLE;
    else if (clk_en)
    begin
      if (!rd_stb)
        rdata <= `RST_NIBBLE;
      else if (hit(addr, `OFS_CONTROL))
        rdata <= waveform_control_reg_q;
      else if (hit(addr, `OFS_DUTY_LOW))
        rdata <= duty_low_q;
      else if (hit(addr, `OFS_DUTY_HIGH))
        rdata <= duty_high_q;
      else if (hit(addr, `OFS_PIN_FUNC))
        rdata <= pin_func_q;
      else
        rdata <= `RST_NIBBLE;
    end
  end

  // ----------------------------------------
  // Run state
  // ----------------------------------------

  pwm_pkg::run_state_t run_q;

  // Halt keeps running, stop freezes the generator
  always_ff @(posedge mclk)
  begin
    if (srst)
      run_q <= pwm_pkg::run_st;
    else if (clk_en)
    begin
      case (run_q)
        pwm_pkg::run_st: if (stop_mode) run_q <= pwm_pkg::stopped_st;
        pwm_pkg::stopped_st: if (!stop_mode) run_q <= pwm_pkg::run_st;
        default: run_q <= pwm_pkg::run_st;
      endcase
    end
  end

  logic active;
  assign active = clk_en && (run_q == pwm_pkg::run_st) && !stop_mode;

  // ----------------------------------------
  // Prescaler and counters
  // ----------------------------------------

  logic [`PRE_W-1:0] pre_q;
  logic tick;
  logic [5:0] pos_q;
  logic [1:0] sub_q;
  pwm_pkg::duty_base_t base_q;
  logic [1:0] fine_q;
  logic sub_end;

  assign tick = active && (pre_q >= pre_last(waveform_control_reg_q[`SEL_HI:0]));
  assign sub_end = tick && (pos_q == `SUB_LAST);
  assign reload_take = sub_end && (sub_q == `SUB_COUNT_LAST);

  // Prescaler divides the oscillator down to the PWM clock
  always_ff @(posedge mclk)
  begin
    if (srst)
      pre_q <= '0;
    else if (active)
      pre_q <= tick ? '0 : pre_q + 1'b1;
  end

  // Position within a sub-cycle and sub-cycle index
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pos_q <= '0;
      sub_q <= '0;
    end
    else if (tick)
    begin
      pos_q <= pos_q + 1'b1;
      if (sub_end)
        sub_q <= sub_q + 1'b1;
    end
  end

  // Reload counter takes the duty only at a period boundary
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      base_q <= '0;
      fine_q <= '0;
    end
    else if (reload_take && reload_req_q)
    begin
      base_q <= {duty_high_q, duty_low_q[`LOWBASE_HI:`LOWBASE_LO]};
      fine_q <= duty_low_q[`FINE_HI:0];
    end
  end

  // ----------------------------------------
  // Waveform
  // ----------------------------------------

  logic [6:0] eff_duty;
  logic raw_high;
  logic wave_d;

  assign eff_duty = {1'b0, base_q} + {6'h00, (sub_q < fine_q)};
  assign raw_high = ({1'b0, pos_q} < eff_duty);
  assign wave_d = raw_high ^ waveform_control_reg_q[`POL_BIT];

  // Registered waveform
  always_ff @(posedge mclk)
  begin
    if (srst)
      pwm_wave <= 1'b0;
    else if (clk_en)
      pwm_wave <= wave_d;
  end

  // Pin routing by the function fields
  logic pin3_sel;
  logic pin2_sel;
  assign pin3_sel = (pin_func_q[`PIN3_HI:`PIN3_LO] == `PIN_PWM_SEL);
  assign pin2_sel = (pin_func_q[`PIN2_HI:`PIN2_LO] == `PIN_PWM_SEL);
  assign pwm_pin_out = pin3_sel & pwm_wave;
  assign pwm_pin_oe = pin3_sel;
  assign alternate_waveform_pin = pin2_sel & pwm_wave;
  assign alternate_waveform_pin_oe = pin2_sel;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // Checker helper: oscillator cycles since the last PWM clock, restarted on a clock-select write
  logic [11:0] gap_q;
  logic gap_ok_q;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      gap_q <= '0;
      gap_ok_q <= 1'b0;
    end
    else if (clk_en && wr_stb && hit(addr, `OFS_CONTROL))
    begin
      gap_q <= '0;
      gap_ok_q <= 1'b0;
    end
    else if (active)
    begin
      gap_q <= tick ? '0 : gap_q + 1'b1;
      gap_ok_q <= gap_ok_q | tick;
    end
  end

  sequence s_period_load;
    reload_take && reload_req_q;
  endsequence

  sequence s_hi_write;
    clk_en && wr_stb && addr == `OFS_DUTY_HIGH;
  endsequence

  AST_DIV1: assert property (@(posedge mclk) disable iff (srst)
    active && waveform_control_reg_q[`SEL_HI:0] == 3'h0 |-> tick)
    else $error("divide by one missed a tick");
  AST_POL: assert property (@(posedge mclk) disable iff (srst)
    clk_en |=> pwm_wave == ($past(raw_high) ^ $past(waveform_control_reg_q[`POL_BIT])))
    else $error("polarity wrong");
  AST_SUBWRAP: assert property (@(posedge mclk) disable iff (srst)
    sub_end |=> pos_q == 6'h00 && sub_q == $past(sub_q) + 2'h1)
    else $error("sub-cycle wrap wrong");
  AST_FINE: assert property (@(posedge mclk) disable iff (srst)
    sub_q == `SUB_COUNT_LAST |-> eff_duty == {1'b0, base_q})
    else $error("last sub-cycle got the fine-tune clock");
  AST_FINE0: assert property (@(posedge mclk) disable iff (srst)
    sub_q == 2'h0 && fine_q != 2'h0 |-> eff_duty == {1'b0, base_q} + 7'h01)
    else $error("first sub-cycle missed the fine-tune clock");
  AST_REQ: assert property (@(posedge mclk) disable iff (srst)
    s_hi_write |=> reload_req_q)
    else $error("reload request lost");
  AST_NOMID: assert property (@(posedge mclk) disable iff (srst)
    !$past(srst) && !$past(reload_take) |-> $stable(base_q))
    else $error("duty changed mid period");
  AST_STOP: assert property (@(posedge mclk) disable iff (srst)
    stop_mode |=> $stable(pos_q) && $stable(pre_q))
    else $error("counter ran in stop");
  AST_PIN: assert property (@(posedge mclk) disable iff (srst)
    pin_func_q[`PIN3_HI:`PIN3_LO] != `PIN_PWM_SEL |-> !pwm_pin_oe && !pwm_pin_out)
    else $error("pin driven while not selected");
  AST_HIGH: assert property (@(posedge mclk) disable iff (srst)
    clk_en && !waveform_control_reg_q[`POL_BIT] && pos_q == 6'h00 && eff_duty != 7'h00 |=> pwm_wave)
    else $error("sub-cycle does not start high");
  AST_DIVN: assert property (@(posedge mclk) disable iff (srst)
    tick && gap_ok_q |-> gap_q + 12'h001 == div_ratio(waveform_control_reg_q[`SEL_HI:0]))
    else $error("PWM clock period wrong");
  AST_LOAD: assert property (@(posedge mclk) disable iff (srst)
    s_period_load |=> base_q == {$past(duty_high_q), $past(duty_low_q[`LOWBASE_HI:`LOWBASE_LO])}
      && fine_q == $past(duty_low_q[`FINE_HI:0]) && pos_q == 6'h00 && sub_q == 2'h0)
    else $error("duty not loaded at the period start");
  AST_HALT: assert property (@(posedge mclk) disable iff (srst)
    halt_mode && active |=> $past(tick) || pre_q == $past(pre_q) + 11'h001)
    else $error("prescaler stalled in halt");

endmodule

/* File: dv/pwm_load_model.sv */
// External load on the PWM pin that measures the length of each run
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic pin,
  input wire logic oe,
  input wire logic lvl,
  output logic [15:0] run_len,
  output logic run_done
);
  logic last_q;
  logic [15:0] cnt_q;
  // Pull-down holds the line low while the pin is released
  wire logic level = oe ? pin : 1'b0;
  // Report each finished run at the watched level
  always_ff @(posedge mclk)
  begin
    run_done <= 1'b0;
    if (srst)
    begin
      last_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else if (level != last_q)
    begin
      run_done <= (last_q == lvl);
      run_len <= cnt_q;
      last_q <= level;
      cnt_q <= 16'h0001;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule

/* File: dv/tb_pwm_six_plus_two_bit.sv */
// Self-checking bench for the PWM block
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module tb_pwm_six_plus_two_bit;
  logic mclk = 0, srst = 1, halt_mode = 0, stop_mode = 0, wr_stb = 0, rd_stb = 0, lvl = 1, rd_d = 0, w;
  logic [7:0] addr = 8'h00;
  logic [3:0] wdata = 4'h0, rdata;
  logic pwm_pin_out, pwm_pin_oe, alt_pin, alt_oe, pwm_wave, run_done;
  logic [15:0] run_len, seed = 16'hc369;
  logic [15:0] rq[$], pq[$];
  logic [7:0] ad[5] = '{`OFS_CONTROL, `OFS_DUTY_LOW, `OFS_DUTY_HIGH, `OFS_PIN_FUNC, 8'h30};
  logic [5:0] d;
  logic [1:0] f;
  int err_total, num_checks, cyc, dv;
  always #50 mclk = ~mclk;
  pwm_six_plus_two_bit u_dut (.mclk(mclk), .srst(srst), .clk_en(1'b1), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe), .alternate_waveform_pin(alt_pin),
    .alternate_waveform_pin_oe(alt_oe), .pwm_wave(pwm_wave));
  pwm_load_model u_load (.mclk(mclk), .srst(srst), .pin(pwm_pin_out), .oe(pwm_pin_oe), .lvl(lvl),
    .run_len(run_len), .run_done(run_done));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [3:0] x);
    @(posedge mclk);
    addr <= a;
    wdata <= x;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [3:0] x);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    rq.push_back({12'h000, x});
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask
  task automatic rst();
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
  endtask
  // Run lengths of one period: base plus one in the first n sub-cycles
  task automatic push_period(logic [5:0] b, logic [1:0] n);
    for (int s = 0; s < 4; s++)
      pq.push_back(16'((b + (s < n)) * dv));
  endtask
  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Compare each answer with the oldest note
  always @(negedge mclk)
  begin
    if (rd_d)
      chk("rdata", rq.pop_front(), {12'h000, rdata});
    rd_d = rd_stb;
    if (run_done && pq.size() > 0)
      chk("run_len", pq.pop_front(), run_len);
    chk("alt_pin", {15'h0000, alt_oe & pwm_wave}, {15'h0000, alt_pin});
  end
  // Cut a hang short
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    rst();
    // Registers clear on reset and keep written values; unmapped place reads zero
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      rd(ad[k], 4'h0);
      wr(ad[k], seed[3:0]);
      rd(ad[k], k == 4 ? 4'h0 : seed[3:0]);
    end
    // One waveform per clock code 0 to 4, polarity alternating, duty changed mid-period
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk);
      rst();
      seed = lfsr(seed);
      d = 6'h01 + 6'(seed % 16'h003e);
      f = seed[9:8];
      dv = 1 << (i == 4 ? 5 : i);
      lvl <= ~i[0];
      halt_mode <= (i == 2);
      wr(`OFS_CONTROL, {1'b0, 3'(i)});
      wr(`OFS_DUTY_LOW, {d[1:0], f});
      wr(`OFS_DUTY_HIGH, d[5:2]);
      wr(`OFS_CONTROL, {i[0], 3'(i)});
      wr(`OFS_PIN_FUNC, i == 4 ? 4'hf : 4'hc);
      repeat (4) @(posedge mclk);
      chk("pin_oe", 16'h0001, {15'h0000, pwm_pin_oe});
      chk("alt_oe", {15'h0000, i == 4}, {15'h0000, alt_oe});
      push_period(d, f);
      wait (pq.size() == 3);
      d = 6'h3f - d;
      wr(`OFS_DUTY_LOW, {d[1:0], 2'h0});
      wr(`OFS_DUTY_HIGH, d[5:2]);
      push_period(d, 2'h0);
      wait (pq.size() == 0);
    end
    // Stop mode freezes a fast waveform
    wr(`OFS_CONTROL, 4'h0);
    stop_mode <= 1'b1;
    repeat (2) @(negedge mclk);
    w = pwm_wave;
    repeat (300)
    begin
      @(negedge mclk);
      chk("stop_wave", {15'h0000, w}, {15'h0000, pwm_wave});
    end
    give_verdict();
  end
endmodule
